/* File: rtl/emulator_run_control.sv */
// Run control of the emulator: hold, step, break substitution and pin gating.
// Behaviour
// RULE1 - Break, dump, step and stop never complete while the bus clock is halted; a break hit still moves to S_HELD without checking alive.
// RULE2 - Holding the MCU stops the program; peripherals keep running.
// RULE3 - All interrupts are masked while a single step is in progress.
// RULE4 - A stepped wait instruction does not enter wait; never step stop.
// RULE5 - User program keeps four spare bytes on the interrupt stack.
// RULE6 - Software break fetches the break instruction, opcode 00, at its address.
// RULE7 - Protect bit opens only when set by free-running code.
// RULE8 - DMA requests and both channel counters keep working during hold.
// RULE9 - Target reset and NMI reach the MCU only while the program runs.
// RULE10 - Debug accesses during a run may steal bus time from the program.
// RULE11 - No software break or stepping on address-match interrupt addresses.
// RULE12 - Commands with the bus clock halted report an error instead of waiting.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
module emulator_run_control (
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  input  wire logic [run_control_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [run_control_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                                  reg_we,
  input  wire logic                                  reg_re,
  output logic      [run_control_pkg::DATA_W-1:0]    reg_rdata_q,
  input  wire logic                                  bclk_pin,
  input  wire logic                                  step_done_pin,
  input  wire logic                                  acc_ack_pin,
  input  wire logic [run_control_pkg::MEM_DW-1:0]    acc_rdata_pin,
  input  wire logic                                  target_reset_n_pin,
  input  wire logic                                  target_nmi_n_pin,
  input  wire logic [1:0]                            dma_req_pin,
  input  wire logic                                  prot_set_pin,
  input  wire logic                                  fetch_valid_pin,
  input  wire logic [run_control_pkg::MEM_AW-1:0]    fetch_addr_pin,
  input  wire logic [run_control_pkg::MEM_DW-1:0]    fetch_op_pin,
  output logic                                       mcu_hold_q,
  output logic                                       int_mask_q,
  output logic                                       wait_block_q,
  output logic                                       periph_run_q,
  output logic                                       mcu_reset_n_q,
  output logic                                       mcu_nmi_n_q,
  output logic                                       run_led_q,
  output logic      [1:0]                            dma_count_en_q,
  output logic                                       acc_req_q,
  output logic                                       acc_we_q,
  output logic      [run_control_pkg::MEM_AW-1:0]    acc_addr_q,
  output logic      [run_control_pkg::MEM_DW-1:0]    acc_wdata_q,
  output logic      [run_control_pkg::MEM_DW-1:0]    fetch_op_q,
  output logic                                       prot_open_q
);
  localparam int PW = run_control_pkg::PIN_W;

  logic [PW-1:0]                     pins_raw;
  logic [PW-1:0]                     pins_s;
  logic                              bclk_s;
  logic                              step_done_s;
  logic                              ack_s;
  logic [run_control_pkg::MEM_DW-1:0] acc_rdata_s;
  logic                              tgt_reset_n_s;
  logic                              tgt_nmi_n_s;
  logic [1:0]                        dma_req_s;
  logic                              prot_set_s;
  logic                              fetch_valid_s;
  logic [run_control_pkg::MEM_AW-1:0] fetch_addr_s;
  logic [run_control_pkg::MEM_DW-1:0] fetch_op_s;
  logic                              alive;

  assign pins_raw = {bclk_pin, step_done_pin, acc_ack_pin, acc_rdata_pin, target_reset_n_pin,
                     target_nmi_n_pin, dma_req_pin, prot_set_pin, fetch_valid_pin,
                     fetch_addr_pin, fetch_op_pin};
  assign {bclk_s, step_done_s, ack_s, acc_rdata_s, tgt_reset_n_s, tgt_nmi_n_s, dma_req_s,
          prot_set_s, fetch_valid_s, fetch_addr_s, fetch_op_s} = pins_s;

  for (genvar i = 0; i < PW; i++) begin : g_sync
    sync2 u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (pins_raw[i]),
      .level_q (pins_s[i])
    );
  end

  bclk_monitor u_mon (
    .clk        (clk),
    .reset_n    (reset_n),
    .bclk_level (bclk_s),
    .alive_q    (alive)
  );

  run_control_pkg::run_state_t        state_q, state_d;
  logic                               ret_run_q, ret_run_d;
  logic                               err_q, err_d;
  logic                               step_flag_q, step_flag_d;
  logic                               step_prev_q, prot_prev_q;
  logic [run_control_pkg::MEM_AW-1:0] brk_addr_q, brk_addr_d;
  logic                               brk_en_q, brk_en_d;
  logic [run_control_pkg::MEM_AW-1:0] mem_addr_d;
  logic [run_control_pkg::MEM_DW-1:0] mem_wdata_d;
  logic [run_control_pkg::MEM_DW-1:0] mem_rdata_q, mem_rdata_d;
  logic                               acc_we_d, acc_req_d;
  logic                               prot_open_d, run_d, hold_d;
  logic [run_control_pkg::MEM_DW-1:0] fetch_op_d;
  logic [run_control_pkg::DATA_W-1:0] rdata_d;
  logic                               cmd_we, busy, brk_hit, step_rise, prot_rise;
  logic                               c_run, c_stop, c_step, c_mem;

  assign cmd_we    = reg_we && (reg_addr == run_control_pkg::OFS_CMD);
  assign c_run     = cmd_we && reg_wdata[run_control_pkg::CMD_RUN];
  assign c_stop    = cmd_we && reg_wdata[run_control_pkg::CMD_STOP];
  assign c_step    = cmd_we && reg_wdata[run_control_pkg::CMD_STEP];
  assign c_mem     = cmd_we && (reg_wdata[run_control_pkg::CMD_MEM_RD] ||
                                reg_wdata[run_control_pkg::CMD_MEM_WR]);
  assign busy      = (state_q == run_control_pkg::S_STEPPING) ||
                     (state_q == run_control_pkg::S_ACCESS) || ack_s;
  assign step_rise = step_done_s && !step_prev_q;
  assign prot_rise = prot_set_s && !prot_prev_q;
  assign brk_hit   = brk_en_q && fetch_valid_s && (fetch_addr_s == brk_addr_q);

  // Next state of the run-control sequencer.
  always_comb begin
    state_d     = state_q;
    ret_run_d   = ret_run_q;
    err_d       = err_q;
    step_flag_d = step_flag_q;
    mem_addr_d  = acc_addr_q;
    mem_wdata_d = acc_wdata_q;
    mem_rdata_d = mem_rdata_q;
    acc_we_d    = acc_we_q;
    acc_req_d   = acc_req_q;
    brk_addr_d  = brk_addr_q;
    brk_en_d    = brk_en_q;
    prot_open_d = prot_open_q;
    if (reg_we && reg_addr == run_control_pkg::OFS_MEM_ADDR && !busy) begin
      mem_addr_d = reg_wdata[run_control_pkg::MEM_AW-1:0];
    end
    if (reg_we && reg_addr == run_control_pkg::OFS_MEM_WDATA && !busy) begin
      mem_wdata_d = reg_wdata[run_control_pkg::MEM_DW-1:0];
    end
    if (reg_we && reg_addr == run_control_pkg::OFS_BRK_ADDR) begin
      brk_addr_d = reg_wdata[run_control_pkg::MEM_AW-1:0];
    end
    if (reg_we && reg_addr == run_control_pkg::OFS_BRK_CTRL) begin
      brk_en_d = reg_wdata[run_control_pkg::BRK_EN];
    end
    if (cmd_we && reg_wdata[run_control_pkg::CMD_CLR_ERR]) begin
      err_d = 1'b0;
    end
    if ((c_stop || c_step || c_mem) && !alive) begin
      err_d = 1'b1; // RULE12
    end
    case (state_q)
      run_control_pkg::S_HELD: begin
        if (c_run) begin
          state_d = run_control_pkg::S_RUNNING;
        end else if (c_step && alive) begin
          state_d     = run_control_pkg::S_STEPPING; // RULE1
          step_flag_d = 1'b0;
        end else if (c_mem && alive && !busy) begin
          state_d   = run_control_pkg::S_ACCESS;
          ret_run_d = 1'b0;
          acc_req_d = 1'b1;
          acc_we_d  = reg_wdata[run_control_pkg::CMD_MEM_WR];
        end
      end
      run_control_pkg::S_RUNNING: begin
        if (prot_rise) begin
          prot_open_d = 1'b1; // RULE7
        end
        if (brk_hit || (c_stop && alive)) begin
          state_d     = run_control_pkg::S_HELD; // RULE1
          prot_open_d = 1'b0; // RULE7
        end else if (c_mem && alive && !busy) begin
          state_d   = run_control_pkg::S_ACCESS; // RULE10
          ret_run_d = 1'b1;
          acc_req_d = 1'b1;
          acc_we_d  = reg_wdata[run_control_pkg::CMD_MEM_WR];
        end
      end
      run_control_pkg::S_STEPPING: begin
        if (step_rise) begin
          state_d     = run_control_pkg::S_HELD;
          step_flag_d = 1'b1;
        end else if (!alive) begin
          state_d = run_control_pkg::S_HELD;
          err_d   = 1'b1; // RULE12
        end
      end
      run_control_pkg::S_ACCESS: begin
        if (ack_s) begin
          state_d   = ret_run_q ? run_control_pkg::S_RUNNING : run_control_pkg::S_HELD;
          acc_req_d = 1'b0;
          if (!acc_we_q) begin
            mem_rdata_d = acc_rdata_s;
          end
        end else if (!alive) begin
          state_d   = ret_run_q ? run_control_pkg::S_RUNNING : run_control_pkg::S_HELD;
          acc_req_d = 1'b0;
          err_d     = 1'b1; // RULE12
        end
      end
      default: begin
        state_d   = run_control_pkg::S_HELD;
        acc_req_d = 1'b0;
      end
    endcase
  end

  // Pin-facing outputs derived from the next state and the break match; register read data.
  always_comb begin
    run_d      = (state_d == run_control_pkg::S_RUNNING) ||
                 (state_d == run_control_pkg::S_ACCESS && ret_run_d);
    hold_d     = !run_d && (state_d != run_control_pkg::S_STEPPING); // RULE2
    fetch_op_d = brk_hit ? run_control_pkg::BREAK_OPCODE : fetch_op_s; // RULE6
    rdata_d    = '0;
    if (reg_re) begin
      case (reg_addr)
        run_control_pkg::OFS_STATUS: begin
          rdata_d[run_control_pkg::ST_RUN]       = run_led_q;
          rdata_d[run_control_pkg::ST_BUSY]      = busy;
          rdata_d[run_control_pkg::ST_ERR]       = err_q;
          rdata_d[run_control_pkg::ST_CLK_OK]    = alive;
          rdata_d[run_control_pkg::ST_STEP_DONE] = step_flag_q;
          rdata_d[run_control_pkg::ST_PROT_OPEN] = prot_open_q;
          rdata_d[run_control_pkg::ST_HELD]      = mcu_hold_q;
        end
        run_control_pkg::OFS_MEM_ADDR:  rdata_d[run_control_pkg::MEM_AW-1:0] = acc_addr_q;
        run_control_pkg::OFS_MEM_WDATA: rdata_d[run_control_pkg::MEM_DW-1:0] = acc_wdata_q;
        run_control_pkg::OFS_MEM_RDATA: rdata_d[run_control_pkg::MEM_DW-1:0] = mem_rdata_q;
        run_control_pkg::OFS_BRK_ADDR:  rdata_d[run_control_pkg::MEM_AW-1:0] = brk_addr_q;
        run_control_pkg::OFS_BRK_CTRL:  rdata_d[run_control_pkg::BRK_EN]     = brk_en_q;
        default:                        rdata_d                              = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q        <= run_control_pkg::S_HELD;
      ret_run_q      <= 1'b0;
      err_q          <= 1'b0;
      step_flag_q    <= 1'b0;
      step_prev_q    <= 1'b0;
      prot_prev_q    <= 1'b0;
      brk_addr_q     <= run_control_pkg::RST_BRK_ADDR;
      brk_en_q       <= 1'b0;
      acc_addr_q     <= run_control_pkg::RST_MEM_ADDR;
      acc_wdata_q    <= run_control_pkg::RST_MEM_DATA;
      mem_rdata_q    <= run_control_pkg::RST_MEM_DATA;
      acc_we_q       <= 1'b0;
      acc_req_q      <= 1'b0;
      prot_open_q    <= 1'b0;
      mcu_hold_q     <= 1'b1;
      int_mask_q     <= 1'b0;
      wait_block_q   <= 1'b0;
      periph_run_q   <= 1'b0;
      mcu_reset_n_q  <= 1'b1;
      mcu_nmi_n_q    <= 1'b1;
      run_led_q      <= 1'b0;
      dma_count_en_q <= 2'h0;
      fetch_op_q     <= run_control_pkg::BREAK_OPCODE;
      reg_rdata_q    <= '0;
    end else begin
      state_q        <= state_d;
      ret_run_q      <= ret_run_d;
      err_q          <= err_d;
      step_flag_q    <= step_flag_d;
      step_prev_q    <= step_done_s;
      prot_prev_q    <= prot_set_s;
      brk_addr_q     <= brk_addr_d;
      brk_en_q       <= brk_en_d;
      acc_addr_q     <= mem_addr_d;
      acc_wdata_q    <= mem_wdata_d;
      mem_rdata_q    <= mem_rdata_d;
      acc_we_q       <= acc_we_d;
      acc_req_q      <= acc_req_d;
      prot_open_q    <= prot_open_d;
      mcu_hold_q     <= hold_d; // RULE2
      int_mask_q     <= (state_d == run_control_pkg::S_STEPPING); // RULE3
      wait_block_q   <= (state_d == run_control_pkg::S_STEPPING); // RULE4
      periph_run_q   <= 1'b1; // RULE2
      mcu_reset_n_q  <= run_d ? tgt_reset_n_s : 1'b1; // RULE9
      mcu_nmi_n_q    <= run_d ? tgt_nmi_n_s : 1'b1; // RULE9
      run_led_q      <= run_d;
      dma_count_en_q <= dma_req_s; // RULE8
      fetch_op_q     <= fetch_op_d;
      reg_rdata_q    <= rdata_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence step_cmd_s;
    (state_q == run_control_pkg::S_HELD) && c_step && alive && !c_run;
  endsequence
  sequence mem_in_run_s;
    (state_q == run_control_pkg::S_RUNNING) && c_mem && alive && !busy && !brk_hit && !c_stop;
  endsequence

  dead_clk_refuse_a: assert property ((c_step || c_mem) && !c_run && !alive // RULE1
    && state_q == run_control_pkg::S_HELD |=> state_q == run_control_pkg::S_HELD)
    else $error("command accepted with bus clock halted");
  dead_clk_error_a: assert property ((c_stop || c_step || c_mem) && !alive // RULE12
    |=> err_q) else $error("halted bus clock did not raise the error flag");
  hold_stop_a: assert property ((state_q == run_control_pkg::S_RUNNING) && c_stop && alive // RULE2
    |=> mcu_hold_q && periph_run_q && !run_led_q) else $error("stop did not hold the MCU");
  step_mask_a: assert property (step_cmd_s |=> int_mask_q && !mcu_hold_q // RULE3
    ##0 (int_mask_q throughout (state_q == run_control_pkg::S_STEPPING)[*1]))
    else $error("interrupts not masked during a step");
  step_wait_a: assert property ((state_q == run_control_pkg::S_STEPPING) // RULE4
    |-> wait_block_q) else $error("wait entry not blocked during a step");
  break_sub_a: assert property (brk_hit |=> fetch_op_q == 8'h00) // RULE6
    else $error("break address did not fetch the break opcode");
  prot_step_a: assert property ((state_q != run_control_pkg::S_RUNNING) && prot_rise // RULE7
    |=> $stable(prot_open_q)) else $error("protect opened outside free run");
  dma_hold_a: assert property (mcu_hold_q |=> dma_count_en_q == $past(dma_req_s)) // RULE8
    else $error("DMA request dropped during hold");
  pin_gate_a: assert property (!run_led_q |-> mcu_reset_n_q && mcu_nmi_n_q) // RULE9
    else $error("target reset or NMI passed while halted");
  bus_steal_a: assert property (mem_in_run_s |=> acc_req_q && !mcu_hold_q && run_led_q) // RULE10
    else $error("debug access during run did not take the bus");
endmodule

/* File: shared/run_control_pkg.sv */
// Constants, register map and state encoding of the emulator run-control block.
package run_control_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MEM_AW = 20;
  localparam int MEM_DW = 8;
  localparam int PIN_W  = 45;

  localparam logic [ADDR_W-1:0] OFS_CMD       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MEM_ADDR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MEM_WDATA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MEM_RDATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_BRK_ADDR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_BRK_CTRL  = 8'h18;

  localparam int CMD_RUN     = 0;
  localparam int CMD_STOP    = 1;
  localparam int CMD_STEP    = 2;
  localparam int CMD_MEM_RD  = 3;
  localparam int CMD_MEM_WR  = 4;
  localparam int CMD_CLR_ERR = 5;

  localparam int ST_RUN       = 0;
  localparam int ST_BUSY      = 1;
  localparam int ST_ERR       = 2;
  localparam int ST_CLK_OK    = 3;
  localparam int ST_STEP_DONE = 4;
  localparam int ST_PROT_OPEN = 5;
  localparam int ST_HELD      = 6;

  localparam int BRK_EN = 0;

  localparam logic [MEM_DW-1:0] BREAK_OPCODE = 8'h00;
  localparam logic [MEM_AW-1:0] RST_BRK_ADDR = 20'h00000;
  localparam logic [MEM_AW-1:0] RST_MEM_ADDR = 20'h00000;
  localparam logic [MEM_DW-1:0] RST_MEM_DATA = 8'h00;

  localparam int CLK_PERIOD_NS    = 100;
  localparam int BCLK_TIMEOUT_NS  = 10000;
  localparam int TO_W             = 8;
  localparam logic [TO_W-1:0] BCLK_TIMEOUT_CYC = TO_W'(BCLK_TIMEOUT_NS / CLK_PERIOD_NS);
  localparam logic [TO_W-1:0] RST_TO_COUNT     = 8'h00;

  typedef enum logic [3:0] {
    S_HELD     = 4'b0001,
    S_RUNNING  = 4'b0010,
    S_STEPPING = 4'b0100,
    S_ACCESS   = 4'b1000
  } run_state_t;
endpackage

/* File: rtl/sync2.sv */
// Two-flop synchroniser for one asynchronous pin.
module sync2 (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level_q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q  <= pin;
      level_q <= meta_q;
    end
  end
endmodule

/* File: rtl/bclk_monitor.sv */
// Watches the synchronised bus clock and reports whether it is still toggling.
module bclk_monitor (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic bclk_level,
  output logic      alive_q
);
  logic                                prev_q;
  logic [run_control_pkg::TO_W-1:0]    count_q;
  logic [run_control_pkg::TO_W-1:0]    count_d;
  logic                                alive_d;

  always_comb begin
    count_d = count_q;
    alive_d = alive_q;
    if (bclk_level != prev_q) begin
      count_d = run_control_pkg::RST_TO_COUNT;
      alive_d = 1'b1;
    end else if (count_q >= run_control_pkg::BCLK_TIMEOUT_CYC) begin
      alive_d = 1'b0;
    end else begin
      count_d = count_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_q  <= 1'b0;
      count_q <= run_control_pkg::RST_TO_COUNT;
      alive_q <= 1'b0;
    end else begin
      prev_q  <= bclk_level;
      count_q <= count_d;
      alive_q <= alive_d;
    end
  end
endmodule

/* File: verification/mcu_model.sv */
// Behavioural model of the evaluation microcontroller on the run-control block's far side.
module mcu_model (
  input  wire logic        clk,
  input  wire logic        osc_on,
  input  wire logic [7:0]  resp_dly,
  input  wire logic        int_mask,
  input  wire logic        acc_req,
  input  wire logic [19:0] acc_addr,
  output logic             bclk,
  output logic             step_done,
  output logic             acc_ack,
  output logic [7:0]       acc_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial begin
    bclk = 1'b0;
    step_done = 1'b0;
    acc_ack = 1'b0;
    acc_rdata = 8'h00;
    cnt = 8'h00;
  end
  // The model neither uses the interrupt stack nor sets address-match interrupts.
  always @(posedge clk) begin
    if (osc_on) begin
      bclk <= ~bclk;
    end
    if (!acc_ack) begin
      acc_rdata <= ~acc_rdata;
    end
    if (!osc_on) begin
      cnt <= 8'h00;
    end else if (int_mask && !step_done) begin
      cnt <= cnt + 8'h01;
      if (cnt == resp_dly) begin
        step_done <= 1'b1;
        cnt <= 8'h00;
      end
    end else if (acc_req && !acc_ack) begin
      cnt <= cnt + 8'h01;
      if (cnt == resp_dly) begin
        acc_ack <= 1'b1;
        acc_rdata <= acc_addr[7:0] ^ 8'h5a;
        cnt <= 8'h00;
      end
    end else begin
      if (!int_mask) begin
        step_done <= 1'b0;
      end
      if (!acc_req) begin
        acc_ack <= 1'b0;
      end
    end
  end
endmodule

/* File: verification/emulator_run_control_tb.sv */
// Self-checking bench of the emulator run-control block.
module emulator_run_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset_n, reg_we, reg_re, tr_n, nmi_n, prot_set, f_valid, osc_on;
  logic [7:0]  reg_addr, f_op, dly, acc_rd, acc_wd, op_o, ma;
  logic [31:0] reg_wdata, reg_rdata, rdata;
  logic [19:0] f_addr, break_instruction, acc_a;
  logic [1:0]  dma, dma_o;
  logic        bclk, sdone, ack, hold, mask, wblk, prun, rst_o, nmi_o, led, req, we_o, popen;
  int          failures, total_checks, i;
  localparam logic [7:0] CMD = run_control_pkg::OFS_CMD;
  localparam logic [7:0] STS = run_control_pkg::OFS_STATUS;

  emulator_run_control emulator_run_control_i (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata), .bclk_pin(bclk), .step_done_pin(sdone), .acc_ack_pin(ack),
    .acc_rdata_pin(acc_rd), .target_reset_n_pin(tr_n), .target_nmi_n_pin(nmi_n),
    .dma_req_pin(dma), .prot_set_pin(prot_set), .fetch_valid_pin(f_valid),
    .fetch_addr_pin(f_addr), .fetch_op_pin(f_op), .mcu_hold_q(hold), .int_mask_q(mask),
    .wait_block_q(wblk), .periph_run_q(prun), .mcu_reset_n_q(rst_o), .mcu_nmi_n_q(nmi_o),
    .run_led_q(led), .dma_count_en_q(dma_o), .acc_req_q(req), .acc_we_q(we_o),
    .acc_addr_q(acc_a), .acc_wdata_q(acc_wd), .fetch_op_q(op_o), .prot_open_q(popen));
  mcu_model mcu_model_i (.clk(clk), .osc_on(osc_on), .resp_dly(dly), .int_mask(mask),
    .acc_req(req), .acc_addr(acc_a), .bclk(bclk), .step_done(sdone), .acc_ack(ack),
    .acc_rdata(acc_rd));

  task automatic test_done();
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rdata = reg_rdata;
  endtask
  task automatic wait_idle();
    for (i = 0; i < 100; i++) begin
      rd(STS);
      if (rdata[run_control_pkg::ST_BUSY] === 1'b0) break;
    end
    if (i == 100) begin
      failures++;
      test_done();
    end
  endtask
  task automatic pins_loop(input logic run);
    repeat (4) begin
      @(posedge clk);
      tr_n <= 1'($urandom);
      nmi_n <= 1'($urandom);
      dma <= 2'($urandom);
      cyc(6);
      chk(rst_o, run ? tr_n : 1'b1, "reset gating");
      chk(nmi_o, run ? nmi_n : 1'b1, "nmi gating");
      chk(dma_o, dma, "dma pass");
      chk(prun, 1'b1, "peripherals stopped");
    end
  endtask
  function automatic logic [31:0] bit_of(input int b);
    return 32'h1 << b;
  endfunction

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    {reset_n, reg_we, reg_re, prot_set, f_valid, osc_on} = '0;
    {tr_n, nmi_n, dma, reg_addr, reg_wdata, f_addr, f_op} = '1;
    dly = 8'h03;
    failures = 0;
    total_checks = 0;
    void'($urandom(94));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(STS);
    chk(rdata, bit_of(run_control_pkg::ST_HELD), "status after reset");
    chk({hold, led}, 2'b10, "held after reset");
    rd(8'h1c);
    chk(rdata, 32'h0, "unmapped read");
    wr(CMD, bit_of(run_control_pkg::CMD_STEP));
    cyc(3);
    rd(STS);
    chk(rdata[run_control_pkg::ST_ERR], 1'b1, "step with dead clock");
    chk(mask, 1'b0, "step started with dead clock");
    wr(CMD, bit_of(run_control_pkg::CMD_CLR_ERR));
    osc_on <= 1'b1;
    cyc(10);
    rd(STS);
    chk(rdata[run_control_pkg::ST_ERR+1 -: 2], 2'b10, "error clear or clock alive");
    wr(CMD, bit_of(run_control_pkg::CMD_STEP));
    cyc(1);
    chk({mask, wblk}, 2'b11, "step masks");
    for (i = 0; i < 60 && mask !== 1'b0; i++) cyc(1);
    chk({mask, hold}, 2'b01, "step end");
    rd(STS);
    chk(rdata[run_control_pkg::ST_STEP_DONE], 1'b1, "step done flag");
    dly = 8'hc8;
    wr(CMD, bit_of(run_control_pkg::CMD_STEP));
    cyc(5);
    osc_on = 1'b0;
    cyc(150);
    rd(STS);
    chk(rdata[run_control_pkg::ST_ERR], 1'b1, "clock death mid step");
    chk({mask, hold}, 2'b01, "abort to held");
    osc_on = 1'b1;
    dly = 8'h03;
    wr(CMD, bit_of(run_control_pkg::CMD_CLR_ERR));
    pins_loop(1'b0);
    ma = 8'($urandom);
    wr(run_control_pkg::OFS_MEM_ADDR, {24'h0, ma});
    wr(run_control_pkg::OFS_MEM_WDATA, 32'h01);
    rd(run_control_pkg::OFS_MEM_WDATA);
    chk(rdata, 32'h01, "access data readback");
    rd(run_control_pkg::OFS_MEM_ADDR);
    chk(rdata, {24'h0, ma}, "access address readback");
    wr(CMD, bit_of(run_control_pkg::CMD_MEM_WR));
    #1;
    chk({req, we_o, acc_a, acc_wd}, {2'b11, 12'h0, ma, 8'h01}, "debug write");
    wait_idle();
    @(posedge clk);
    prot_set <= 1'b1;
    cyc(6);
    prot_set <= 1'b0;
    chk(popen, 1'b0, "protect opened while held");
    wr(CMD, bit_of(run_control_pkg::CMD_RUN));
    cyc(2);
    chk({hold, led}, 2'b01, "run");
    pins_loop(1'b1);
    wr(CMD, bit_of(run_control_pkg::CMD_MEM_RD));
    wait_idle();
    rd(run_control_pkg::OFS_MEM_RDATA);
    chk(rdata, {24'h0, ma ^ 8'h5a}, "debug read data");
    chk(led, 1'b1, "run lost in access");
    @(posedge clk);
    prot_set <= 1'b1;
    cyc(6);
    prot_set <= 1'b0;
    chk(popen, 1'b1, "protect not opened in run");
    break_instruction = 20'($urandom);
    wr(run_control_pkg::OFS_BRK_ADDR, {12'h0, break_instruction});
    wr(run_control_pkg::OFS_BRK_CTRL, bit_of(run_control_pkg::BRK_EN));
    rd(run_control_pkg::OFS_BRK_ADDR);
    chk(rdata, {12'h0, break_instruction}, "break address readback");
    rd(run_control_pkg::OFS_BRK_CTRL);
    chk(rdata, bit_of(run_control_pkg::BRK_EN), "break enable readback");
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk);
      f_valid <= 1'b1;
      f_addr <= break_instruction ^ 20'(k);
      f_op <= 8'($urandom) | 8'h01;
      cyc(6);
      chk(op_o, k ? f_op : run_control_pkg::BREAK_OPCODE, "fetch opcode");
      chk({hold, led}, k ? 2'b01 : 2'b10, "break stop");
      f_valid <= 1'b0;
    end
    chk(popen, 1'b0, "protect kept over break");
    wr(CMD, bit_of(run_control_pkg::CMD_RUN));
    wr(CMD, bit_of(run_control_pkg::CMD_STOP));
    cyc(2);
    chk({hold, led, prun}, 3'b101, "forced stop");
    test_done();
  end
endmodule
